// ===== ee_bus_master.sv
// two-wire bus master model that clocks bytes into the slave
`timescale 1ns/1ps
module ee_bus_master (
  input wire logic clk_sys,
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  logic odd_r;
  // idle bus: clock parked high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    odd_r = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  // data moves mid-low only; high phase alternates 6/7 clocks for 125 ns
  task automatic bit_x(input logic b, output logic s);
    tick(3);
    sda_pull <= ~b;
    tick(3);
    scl <= 1'b1;
    tick(3);
    s = sda;
    tick(3 + int'(odd_r));
    scl <= 1'b0;
    odd_r = ~odd_r;
  endtask : bit_x
  task automatic bstart();
    tick(3);
    sda_pull <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sda_pull <= 1'b1;
    tick(3);
    scl <= 1'b0;
  endtask : bstart
  // clock stays high after stop, the link stands still between frames
  task automatic bstop();
    tick(3);
    sda_pull <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sda_pull <= 1'b0;
    tick(6);
  endtask : bstop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], s);
    end
    bit_x(1'b1, s);
    ack = ~s;
  endtask : wbyte
  task automatic rbyte(output logic [7:0] d, input logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, s);
      d[i] = s;
    end
    bit_x(~ack, s);
  endtask : rbyte
endmodule : ee_bus_master

// ===== ee_params.svh
// constants for the serial eeprom slave front end
`ifndef EE_PARAMS_SVH
`define EE_PARAMS_SVH
`define EE_TW_US 5000
`define EE_CLK_MHZ 100
`define EE_TMR_W 19
`define EE_AW 11
`define EE_DEPTH 2048
`define EE_PAGE_LEN 16
`define EE_LAST_BIT 4'h7
`define EE_ACK_CNT 4'h8
`define EE_TEN_CNT 4'h1
`define EE_SEL_TYPE 7:4
`define EE_SEL_RW 0
`define EE_ROW 10:4
`define EE_COL 3:0
`define EE_HI 10:8
`define EE_LO 7:0
`endif

// ===== ee_pkg.sv
// types shared by the serial eeprom slave front end
package ee_pkg;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_DEV   = 6'h02,
    ST_ADDR  = 6'h04,
    ST_WDATA = 6'h08,
    ST_RDATA = 6'h10,
    ST_RNACK = 6'h20
  } ee_state_t;
  typedef struct packed {
    logic scl;
    logic sda;
  } ee_pins_t;
endpackage : ee_pkg

// ===== ee_slave_wr.sv
// two-wire eeprom slave: framing, select decode, write path, read stream
`timescale 1ns/1ps
`include "ee_params.svh"
// Contract
// - write-protect high blocks all array writes; low permits them. Here only high from start to address end blocks; later rises do not.
// - an unconnected write-protect input reads as low, writes allowed.
// - with write-protect high, select and address acked, data bytes not.
// - start is sda falling while scl stays high; commands begin there.
// - outside a write cycle watch for start; ignore bus until one.
// - stop is sda rising while scl stays high; ends the exchange.
// - in a read, only stop after a not-acked byte forces standby.
// - receiver pulls sda low in the ninth clock to acknowledge.
// - sda sampled on each scl rise; master changes it while scl low.
// - first byte msb first: 4-bit type, 3-bit enable, direction bit.
// - type field must equal the fixed array type, else not addressed.
// - respond only when enable field equals the chip-enable pins.
// - larger variants reuse enable bits as address bits 8 to 10.
// - eighth select bit: 1 means read, 0 means write.
// - match acks in ninth bit; mismatch releases bus until next start.
// - write select acked, then address byte acked, then data bytes.
// - write-protect high from start to address end blocks data bytes.
// - single byte write acked if permitted, else nacked and unchanged.
// - page write takes 16 bytes; only low 4 address bits increment.
// - overrun wraps within the row, overwriting earlier latched bytes.
// - write cycle starts only on stop right after an ack slot.
// - during the write cycle sda input is ignored, no requests served.
// - polling select gets no ack while busy, ack once finished.
// - address counter advances after every byte output in a read.
module ee_slave_wr import ee_pkg::*; #(
  parameter int unsigned TW_CYC = `EE_TW_US * `EE_CLK_MHZ,
  parameter int unsigned HI_BITS = 0,
  parameter logic [3:0] DEV_TYPE = 4'h5 // arbitrary type code
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic write_protect_in,
  input wire logic chip_sel_pin0,
  input wire logic chip_sel_pin1,
  input wire logic chip_sel_pin2,
  output logic write_busy
);
  ee_pins_t pin_m_r, pin_s_r, pin_d_r;
  logic wp_m_r, wp_s_r;
  ee_state_t st_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r, tx_r;
  logic ack_pend_r, acked_r, wp_lock_r, busy_r, oe_r;
  logic [`EE_AW-1:0] addr_r;
  logic [`EE_TMR_W-1:0] tmr_r;
  logic [7:0] page_r [0:`EE_PAGE_LEN-1];
  logic [`EE_PAGE_LEN-1:0] mask_r;
  logic [7:0] mem_r [0:`EE_DEPTH-1];
  logic scl_rise_w, scl_fall_w, start_w, stop_w, byte_done_w;
  logic sel_ok_w, trig_w, expire_w;
  logic [7:0] byte_w;
  logic [2:0] pins_w;

  // enable field compare; bits used as address bits are not compared
  function automatic logic sel_match(input logic [7:0] b,
                                     input logic [2:0] p);
    logic ok;
    ok = (b[`EE_SEL_TYPE] == DEV_TYPE);
    for (int i = 0; i < 3; i++) begin
      if (i >= HI_BITS && b[i+1] != p[i]) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : sel_match

  // high address bits carried in the select byte, zero where unused
  function automatic logic [2:0] sel_hi(input logic [7:0] b);
    logic [2:0] h;
    h = 3'h0;
    for (int i = 0; i < 3; i++) begin
      if (i < HI_BITS) begin
        h[i] = b[i+1];
      end
    end
    return h;
  endfunction : sel_hi

  // pins cross into clk_sys through two flops; third stage finds edges
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_m_r <= '1;
      pin_s_r <= '1;
      pin_d_r <= '1;
    end else begin
      pin_m_r <= '{scl: scl_in, sda: sda_in};
      pin_s_r <= pin_m_r;
      pin_d_r <= pin_s_r;
    end
  end

  // a floating pad is pulled down outside, so reset value low permits
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wp_m_r <= 1'b0;
      wp_s_r <= 1'b0;
    end else begin
      wp_m_r <= write_protect_in;
      wp_s_r <= wp_m_r;
    end
  end

  // bus events seen on the synchronised copies
  assign pins_w = {chip_sel_pin2, chip_sel_pin1, chip_sel_pin0};
  assign scl_rise_w = pin_s_r.scl & ~pin_d_r.scl;
  assign scl_fall_w = ~pin_s_r.scl & pin_d_r.scl;
  assign start_w = pin_s_r.scl & pin_d_r.scl & pin_d_r.sda
                   & ~pin_s_r.sda;
  assign stop_w = pin_s_r.scl & pin_d_r.scl & ~pin_d_r.sda
                  & pin_s_r.sda;
  assign byte_done_w = scl_rise_w && cnt_r == `EE_LAST_BIT
                       && st_r != ST_IDLE && st_r != ST_RNACK;
  assign byte_w = {shift_r[6:0], pin_s_r.sda};
  assign sel_ok_w = sel_match(byte_w, pins_w);
  assign trig_w = stop_w && !busy_r && st_r == ST_WDATA
                  && cnt_r == `EE_TEN_CNT && acked_r
                  && mask_r != '0;
  assign expire_w = busy_r && tmr_r == `EE_TMR_W'(TW_CYC - 1);

  // protocol state; busy forces idle so nothing on the bus is seen
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
    end else if (busy_r) begin
      st_r <= ST_IDLE;
    end else if (start_w) begin
      st_r <= ST_DEV;
    end else if (stop_w && st_r != ST_RDATA) begin
      st_r <= ST_IDLE;
    end else if (byte_done_w) begin
      unique case (st_r)
        ST_DEV: begin
          if (!sel_ok_w) begin
            st_r <= ST_IDLE;
          end else if (byte_w[`EE_SEL_RW]) begin
            st_r <= ST_RDATA;
          end else begin
            st_r <= ST_ADDR;
          end
        end
        ST_ADDR: st_r <= ST_WDATA;
        ST_WDATA: st_r <= ST_WDATA;
        ST_RDATA: st_r <= ST_RDATA;
        ST_IDLE: st_r <= ST_IDLE;
        ST_RNACK: st_r <= ST_RNACK;
      endcase
    end else if (scl_rise_w && cnt_r == `EE_ACK_CNT
                 && st_r == ST_RDATA && pin_s_r.sda) begin
      st_r <= ST_RNACK;
    end
  end

  // bit counter 0..8, slot 8 being the acknowledge clock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
    end else if (busy_r || start_w) begin
      cnt_r <= 4'h0;
    end else if (scl_rise_w && st_r != ST_IDLE) begin
      cnt_r <= (cnt_r == `EE_ACK_CNT) ? 4'h0 : cnt_r + 4'h1;
    end
  end

  // msb-first shift register sampled on scl rise
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= 8'h00;
    end else if (scl_rise_w) begin
      shift_r <= byte_w;
    end
  end

  // ack decision per byte; write protect only refuses data bytes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_pend_r <= 1'b0;
      acked_r <= 1'b0;
    end else if (busy_r || start_w) begin
      ack_pend_r <= 1'b0;
      acked_r <= 1'b0;
    end else if (byte_done_w) begin
      unique case (st_r)
        ST_DEV: ack_pend_r <= sel_ok_w;
        ST_ADDR: ack_pend_r <= 1'b1;
        ST_WDATA: ack_pend_r <= !wp_lock_r;
        default: ack_pend_r <= 1'b0;
      endcase
      acked_r <= (st_r == ST_WDATA) && !wp_lock_r;
    end
  end

  // protect seen anywhere from start to address end locks the command
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wp_lock_r <= 1'b0;
    end else if (start_w) begin
      wp_lock_r <= wp_s_r;
    end else if ((st_r == ST_DEV || st_r == ST_ADDR) && wp_s_r) begin
      wp_lock_r <= 1'b1;
    end
  end

  // address counter; writes step only the in-row bits so they wrap
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= '0;
    end else if (byte_done_w && !busy_r) begin
      if (st_r == ST_DEV && sel_ok_w) begin
        addr_r[`EE_HI] <= sel_hi(byte_w);
      end else if (st_r == ST_ADDR) begin
        addr_r[`EE_LO] <= byte_w;
      end else if (st_r == ST_WDATA && !wp_lock_r) begin
        addr_r[`EE_COL] <= addr_r[`EE_COL] + 4'h1;
      end else if (st_r == ST_RDATA) begin
        addr_r <= addr_r + `EE_AW'(1);
      end
    end
  end

  // read byte loaded on every select byte and on each master ack
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_r <= 8'h00;
    end else if (byte_done_w && st_r == ST_DEV) begin
      tx_r <= mem_r[{sel_hi(byte_w), addr_r[`EE_LO]}];
    end else if (scl_rise_w && st_r == ST_RDATA
                 && cnt_r == `EE_ACK_CNT && !pin_s_r.sda) begin
      tx_r <= mem_r[addr_r];
    end
  end

  // open-drain drive changes only while scl is low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      oe_r <= 1'b0;
    end else if (busy_r || start_w || stop_w) begin
      oe_r <= 1'b0;
    end else if (scl_fall_w) begin
      if (cnt_r == `EE_ACK_CNT) begin
        oe_r <= ack_pend_r;
      end else begin
        oe_r <= st_r == ST_RDATA
                && !tx_r[3'(`EE_LAST_BIT - cnt_r)];
      end
    end
  end

  // page latches; a later byte at the same column replaces the older
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= '0;
    end else if (expire_w || (start_w && !busy_r)) begin
      mask_r <= '0;
    end else if (byte_done_w && st_r == ST_WDATA && !wp_lock_r) begin
      mask_r[addr_r[`EE_COL]] <= 1'b1;
    end
  end

  // data storage has no reset, as a real array keeps its contents
  always_ff @(posedge clk_sys) begin
    if (byte_done_w && st_r == ST_WDATA && !wp_lock_r) begin
      page_r[addr_r[`EE_COL]] <= byte_w;
    end
    if (expire_w) begin
      for (int i = 0; i < `EE_PAGE_LEN; i++) begin
        if (mask_r[i]) begin
          mem_r[{addr_r[`EE_ROW], 4'(i)}] <= page_r[i];
        end
      end
    end
  end

  // self-timed write cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      tmr_r <= '0;
    end else if (trig_w) begin
      busy_r <= 1'b1;
      tmr_r <= '0;
    end else if (expire_w) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      tmr_r <= tmr_r + `EE_TMR_W'(1);
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = oe_r;
  assign write_busy = busy_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_wp_data_nack: assert property (byte_done_w && st_r == ST_WDATA
    && wp_lock_r |=> !ack_pend_r && !acked_r)
    else $error("data byte acked under write protect");
  a_wp_no_write: assert property ($rose(busy_r)
    |-> $past(!wp_lock_r && acked_r))
    else $error("write cycle started while protected");
  a_busy_quiet: assert property (busy_r ##1 busy_r
    |-> !oe_r && st_r == ST_IDLE)
    else $error("bus served during write cycle");
  a_start_sel: assert property (start_w && !busy_r
    |=> st_r == ST_DEV && cnt_r == 4'h0)
    else $error("start not taken");
  a_stop_idle: assert property (stop_w && !busy_r
    && st_r != ST_RDATA |=> st_r == ST_IDLE)
    else $error("stop did not end exchange");
  a_read_stop: assert property (stop_w && st_r == ST_RDATA
    && !busy_r && !start_w |=> st_r == ST_RDATA)
    else $error("stop forced standby without nack");
  a_sel_ack: assert property (byte_done_w && st_r == ST_DEV
    && !busy_r |=> ack_pend_r == $past(sel_ok_w))
    else $error("select ack decision wrong");
  a_ack_drive: assert property (scl_fall_w && ack_pend_r
    && cnt_r == `EE_ACK_CNT && !busy_r && !start_w && !stop_w
    |=> oe_r)
    else $error("ack not driven in ninth slot");
  a_page_wrap: assert property (byte_done_w && st_r == ST_WDATA
    && !wp_lock_r && !busy_r
    |=> addr_r[`EE_COL] == $past(addr_r[`EE_COL]) + 4'h1
    && addr_r[`EE_ROW] == $past(addr_r[`EE_ROW]))
    else $error("page address step wrong");
  a_trig_slot: assert property ($rose(busy_r)
    |-> $past(stop_w && cnt_r == `EE_TEN_CNT && st_r == ST_WDATA))
    else $error("write cycle started outside tenth slot");
  a_busy_len: assert property ($fell(busy_r)
    |-> $past(tmr_r) == `EE_TMR_W'(TW_CYC - 1))
    else $error("write cycle length wrong");
  a_read_inc: assert property (byte_done_w && st_r == ST_RDATA
    && !busy_r |=> addr_r == $past(addr_r) + `EE_AW'(1))
    else $error("read address not advanced");

  c_write_cycle: cover property ($rose(busy_r));
  c_read_nack: cover property (st_r == ST_RDATA ##1 st_r == ST_RNACK);
  c_wp_refuse: cover property (st_r == ST_WDATA && wp_lock_r
    && cnt_r == `EE_ACK_CNT);
endmodule : ee_slave_wr

// ===== i2c_eeprom_slave_write_ctrl_bench.sv
// self-checking bench for the serial eeprom slave write path
`timescale 1ns/1ps
module i2c_eeprom_slave_write_ctrl_bench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic wp_en = 1'b0;
  logic wp_val = 1'b0;
  logic cs0 = 1'b0;
  logic cs1 = 1'b0;
  logic cs2 = 1'b1;
  logic m_scl, m_pull, d_oe, d_out, busy;
  logic [7:0] rd;
  int mismatches = 0;
  int num_checks = 0;
  tri0 wp_pin;
  wire sda_line;
  // floating protect pin falls to the pad pull-down
  assign wp_pin = wp_en ? wp_val : 1'bz;
  // open-drain data line with pull-up
  assign sda_line = ~(m_pull | (d_oe & ~d_out));
  always #5 clk_sys = ~clk_sys;
  ee_slave_wr #(.TW_CYC(200), .HI_BITS(1)) DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(m_scl), .sda_in(sda_line),
    .sda_out(d_out), .sda_oe(d_oe), .write_protect_in(wp_pin),
    .chip_sel_pin0(cs0), .chip_sel_pin1(cs1), .chip_sel_pin2(cs2),
    .write_busy(busy));
  ee_bus_master mst (.clk_sys(clk_sys), .scl(m_scl), .sda_pull(m_pull),
    .sda(sda_line));
  task automatic chk_bit(input string what, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %b seen %b", what, e, g);
    end
  endtask : chk_bit
  task automatic chk_byte(input string what, input logic [7:0] e,
                          input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk_byte
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic send(input logic [7:0] b, input logic e, input string what);
    logic ack;
    mst.wbyte(b, ack);
    chk_bit(what, e, ack);
  endtask : send
  // bounded wait for the self-timed cycle to end
  task automatic wait_idle(input int n);
    for (int i = 0; i < n && busy !== 1'b0; i++) @(posedge clk_sys);
    chk_bit("write_busy end", 1'b0, busy);
    // a cycle that never ends leaves nothing more worth running
    if (busy !== 1'b0) begin
      close_out();
    end
  endtask : wait_idle
  // guard against a hung handshake
  initial begin
    repeat (60000) @(posedge clk_sys);
    mismatches++;
    $display("ERROR run_time expected end seen timeout");
    close_out();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk_bit("busy reset", 1'b0, busy);
    chk_bit("sda_oe reset", 1'b0, d_oe);
    mst.bstart();
    send(8'h6A, 1'b0, "wrong type");
    mst.bstart();
    send(8'h52, 1'b0, "wrong enable");
    mst.bstop();
    // page write at column 14; pin0 differs from address bit 8
    mst.bstart();
    send(8'h5A, 1'b1, "write select");
    send(8'h2E, 1'b1, "address");
    for (int i = 0; i < 18; i++) send(8'h30 + 8'(i), 1'b1, "page");
    mst.bstop();
    chk_bit("busy after stop", 1'b1, busy);
    mst.bstart();
    send(8'h5A, 1'b0, "poll busy");
    wait_idle(300);
    mst.bstart();
    send(8'h5A, 1'b1, "poll done");
    mst.bstop();
    chk_bit("busy no data", 1'b0, busy);
    // whole row back; overrun left bytes 16 and 17 at columns 14 and 15
    mst.bstart();
    send(8'h5A, 1'b1, "dummy select");
    send(8'h20, 1'b1, "read address");
    mst.bstart();
    send(8'h5B, 1'b1, "read select");
    for (int c = 0; c < 16; c++) begin
      mst.rbyte(rd, c != 15);
      chk_byte("row data", 8'h32 + 8'(c), rd);
    end
    mst.bstop();
    chk_bit("busy after read", 1'b0, busy);
    // protected write: select and address acked, data refused
    wp_en <= 1'b1;
    wp_val <= 1'b1;
    mst.bstart();
    send(8'h5A, 1'b1, "wp select");
    send(8'h20, 1'b1, "wp address");
    send(8'hA5, 1'b0, "wp data");
    mst.bstop();
    chk_bit("busy wp", 1'b0, busy);
    wp_val <= 1'b0;
    mst.bstart();
    send(8'h5A, 1'b1, "check select");
    send(8'h20, 1'b1, "check address");
    mst.bstart();
    send(8'h5B, 1'b1, "check read");
    mst.rbyte(rd, 1'b0);
    chk_byte("wp kept", 8'h32, rd);
    mst.bstop();
    // standby after nack and stop; counter has moved on
    mst.bstart();
    send(8'h5B, 1'b1, "current read");
    mst.rbyte(rd, 1'b0);
    chk_byte("next byte", 8'h33, rd);
    mst.bstop();
    close_out();
  end
endmodule : i2c_eeprom_slave_write_ctrl_bench
